// file: include/lane_steer_pkg.sv
// Purpose: shared constants and types for the static memory byte lane steering block
// Assumes: 32-bit internal bus, banks of 8, 16 or 32 bits
// Notes:   little-endian steering only
package lane_steer_pkg;
  localparam logic [1:0] WIDTH_8   = 2'h0;
  localparam logic [1:0] WIDTH_16  = 2'h1;
  localparam logic [1:0] WIDTH_32  = 2'h2;
  localparam logic [1:0] SIZE_BYTE = 2'h0;
  localparam logic [1:0] SIZE_HALF = 2'h1;
  localparam logic [1:0] SIZE_WORD = 2'h2;
  localparam logic [3:0] LANES_ALL = 4'hF;
  localparam logic [3:0] LANES_OFF = 4'h0;
  localparam logic [31:0] DATA_RST = 32'h0;

  typedef struct packed {
    logic [1:0] size;
    logic [1:0] addr;
    logic [1:0] width;
  } req_s;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_RD   = 4'b0010,
    ST_WR   = 4'b0100,
    ST_DONE = 4'b1000
  } state_e;
endpackage

// file: hdl/lane_steer.sv
// Purpose: byte lane selects, write lane drive enables and read assembly
// Assumes: one external transfer completes per cycle that EXT_ACK is high
// Notes:   transfers issue in ascending external address order
`timescale 1ns/1ps
module lane_steer
  import lane_steer_pkg::*;
(
  input  wire logic        MCLK,
  input  wire logic        RST,
  input  wire logic        REQ_VALID,
  input  wire logic        REQ_WRITE,
  input  wire req_s        REQ,
  input  wire logic        READ_LANE_SELECT_ENABLE,
  input  wire logic [31:0] INT_WRITE_DATA,
  input  wire logic [31:0] EXT_DATA_BUS,
  input  wire logic        EXT_ACK,
  output logic             REQ_READY,
  output logic             EXT_STROBE,
  output logic [1:0]       EXT_ADDRESS,
  output logic [3:0]       BYTE_LANE_SELECT_N,
  output logic [3:0]       WRITE_LANE_DRIVE_EN_N,
  output logic [31:0]      EXT_WRITE_DATA,
  output logic [31:0]      INT_READ_DATA,
  output logic             RDATA_VALID
);

  state_e      state_r;
  req_s        req_r;
  logic [1:0]  beat_r;
  logic [1:0]  last_r;
  logic [31:0] hold_r;
  logic        read_lane_select_enable_r;

  // number of external transfers minus one
  function automatic logic [1:0] beats(input req_s q);
    if (q.width == WIDTH_8)
      return (q.size == SIZE_WORD) ? 2'h3 : (q.size == SIZE_HALF) ? 2'h1 : 2'h0;
    else if (q.width == WIDTH_16)
      return (q.size == SIZE_WORD) ? 2'h1 : 2'h0;
    return 2'h0;
  endfunction

  // external address of a transfer
  function automatic logic [1:0] ext_addr(input req_s q, input logic [1:0] b);
    if (q.width == WIDTH_8) begin
      if (q.size == SIZE_WORD) return b;
      if (q.size == SIZE_HALF) return {q.addr[1], b[0]};
      return q.addr;
    end
    if (q.width == WIDTH_16) begin
      if (q.size == SIZE_WORD) return {b[0], 1'b0};
      return {q.addr[1], 1'b0};
    end
    return 2'h0;
  endfunction

  // merge one transfer into the holding word
  function automatic logic [31:0] merge(input req_s q, input logic [1:0] a,
                                        input logic [31:0] d, input logic [31:0] h);
    logic [31:0] r;
    r = h;
    unique case (q.width)
      WIDTH_8: r[a*8 +: 8] = d[7:0];
      WIDTH_16: begin
        if (q.size == SIZE_BYTE)
          r[q.addr*8 +: 8] = q.addr[0] ? d[15:8] : d[7:0];
        else
          r[a[1]*16 +: 16] = d[15:0];
      end
      default: r = d;
    endcase
    return r;
  endfunction

  // lanes written for the request on a given width
  function automatic logic [3:0] wr_lanes(input req_s q);
    logic [3:0] m;
    m = (q.size == SIZE_WORD) ? 4'hF : (q.size == SIZE_HALF) ? 4'h3 : 4'h1;
    if (q.width == WIDTH_8) return 4'h1;
    if (q.width == WIDTH_16) return (q.size == SIZE_BYTE) ? (4'h1 << q.addr[0]) : 4'h3;
    return (q.size == SIZE_WORD) ? m : m << {q.addr[1], (q.size == SIZE_BYTE) & q.addr[0]};
  endfunction

  wire logic [1:0] cur_addr = ext_addr(req_r, beat_r);
  // address of the first transfer of a request being taken
  wire logic [1:0]  first_addr = ext_addr(REQ, 2'h0);
  wire logic [15:0] ext_low    = EXT_DATA_BUS[15:0];

  always_ff @(posedge MCLK) begin
    if (RST) begin
      state_r <= ST_IDLE;
    end else begin
      unique case (state_r)
        ST_IDLE: if (REQ_VALID) state_r <= REQ_WRITE ? ST_WR : ST_RD;
        ST_RD:   if (EXT_ACK && beat_r == last_r) state_r <= ST_DONE;
        ST_WR:   if (EXT_ACK && beat_r == last_r) state_r <= ST_IDLE;
        ST_DONE: state_r <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge MCLK) begin
    if (RST) begin
      req_r  <= '0;
      read_lane_select_enable_r <= 1'b0;
      last_r <= 2'h0;
    end else if (state_r == ST_IDLE && REQ_VALID) begin
      req_r  <= REQ;
      read_lane_select_enable_r <= READ_LANE_SELECT_ENABLE;
      last_r <= beats(REQ);
    end
  end

  always_ff @(posedge MCLK) begin
    if (RST || state_r == ST_IDLE) begin
      beat_r <= 2'h0;
    end else if (EXT_ACK && beat_r != last_r) begin
      beat_r <= beat_r + 2'h1;
    end
  end

  always_ff @(posedge MCLK) begin
    if (RST || state_r == ST_IDLE) begin
      hold_r <= DATA_RST;
    end else if (state_r == ST_RD && EXT_ACK) begin
      hold_r <= merge(req_r, cur_addr, EXT_DATA_BUS, hold_r);
    end
  end

  always_ff @(posedge MCLK) begin
    if (RST) begin
      INT_READ_DATA <= DATA_RST;
      RDATA_VALID   <= 1'b0;
    end else begin
      RDATA_VALID <= state_r == ST_RD && EXT_ACK && beat_r == last_r;
      if (state_r == ST_RD && EXT_ACK && beat_r == last_r)
        INT_READ_DATA <= merge(req_r, cur_addr, EXT_DATA_BUS, hold_r);
    end
  end

  always_ff @(posedge MCLK) begin
    if (RST) begin
      REQ_READY  <= 1'b1;
      EXT_STROBE <= 1'b0;
      EXT_ADDRESS <= 2'h0;
    end else begin
      REQ_READY  <= (state_r == ST_IDLE && !REQ_VALID) || state_r == ST_DONE ||
                    (state_r == ST_WR && EXT_ACK && beat_r == last_r);
      EXT_STROBE <= (state_r == ST_IDLE && REQ_VALID) ||
                    ((state_r == ST_RD || state_r == ST_WR) &&
                     !(EXT_ACK && beat_r == last_r));
      if (state_r == ST_IDLE && REQ_VALID)
        EXT_ADDRESS <= ext_addr(REQ, 2'h0);
      else if (EXT_ACK && beat_r != last_r)
        EXT_ADDRESS <= ext_addr(req_r, beat_r + 2'h1);
    end
  end

  always_ff @(posedge MCLK) begin
    if (RST) begin
      BYTE_LANE_SELECT_N <= LANES_ALL;
    end else if (state_r == ST_IDLE && REQ_VALID) begin
      if (REQ_WRITE)
        BYTE_LANE_SELECT_N <= ~wr_lanes(REQ);
      else
        BYTE_LANE_SELECT_N <= READ_LANE_SELECT_ENABLE ? LANES_OFF : LANES_ALL;
    end else if ((state_r == ST_RD || state_r == ST_WR) && EXT_ACK && beat_r == last_r) begin
      BYTE_LANE_SELECT_N <= LANES_ALL;
    end
  end

  // every state, write included: every lane driven so nothing floats
  always_ff @(posedge MCLK) begin
    if (RST) begin
      WRITE_LANE_DRIVE_EN_N <= LANES_OFF;
      EXT_WRITE_DATA        <= DATA_RST;
    end else begin
      WRITE_LANE_DRIVE_EN_N <= LANES_OFF;
      if (state_r == ST_IDLE && REQ_VALID && REQ_WRITE) begin
        unique case (REQ.width)
          WIDTH_8:  EXT_WRITE_DATA <= {4{INT_WRITE_DATA[first_addr*8 +: 8]}};
          WIDTH_16: EXT_WRITE_DATA <= {2{INT_WRITE_DATA[first_addr[1]*16 +: 16]}};
          default:  EXT_WRITE_DATA <= INT_WRITE_DATA;
        endcase
      end else if (state_r == ST_WR && EXT_ACK && beat_r != last_r) begin
        if (req_r.width == WIDTH_8)
          EXT_WRITE_DATA <= {4{INT_WRITE_DATA[ext_addr(req_r, beat_r + 2'h1)*8 +: 8]}};
        else
          EXT_WRITE_DATA <= {2{INT_WRITE_DATA[31:16]}};
      end
    end
  end

  property p_read_lanes;
    @(posedge MCLK) disable iff (RST)
      (state_r == ST_IDLE && REQ_VALID && !REQ_WRITE) |=>
        BYTE_LANE_SELECT_N == (read_lane_select_enable_r ? LANES_OFF : LANES_ALL) [*1];
  endproperty
  a_read_lanes: assert property (p_read_lanes) else $error("read lane selects wrong");

  property p_read_hold;
    @(posedge MCLK) disable iff (RST)
      (state_r == ST_RD && !read_lane_select_enable_r) |-> BYTE_LANE_SELECT_N == LANES_ALL;
  endproperty
  a_read_hold: assert property (p_read_hold) else $error("lane select asserted on 8-bit read");

  property p_no_float;
    @(posedge MCLK) disable iff (RST) WRITE_LANE_DRIVE_EN_N == LANES_OFF;
  endproperty
  a_no_float: assert property (p_no_float) else $error("external lane left floating");

  property p_beats8;
    @(posedge MCLK) disable iff (RST)
      (state_r == ST_RD && req_r.width == WIDTH_8 && req_r.size == SIZE_WORD) |->
        last_r == 2'h3;
  endproperty
  a_beats8: assert property (p_beats8) else $error("8-bit word not four transfers");

  property p_half8;
    @(posedge MCLK) disable iff (RST)
      (state_r == ST_RD && req_r.width == WIDTH_8 && req_r.size == SIZE_HALF) |->
        EXT_ADDRESS[1] == req_r.addr[1];
  endproperty
  a_half8: assert property (p_half8) else $error("8-bit halfword address wrong");

  property p_valid_end;
    @(posedge MCLK) disable iff (RST)
      RDATA_VALID |-> $past(state_r == ST_RD && beat_r == last_r && EXT_ACK);
  endproperty
  a_valid_end: assert property (p_valid_end) else $error("read data returned early");

  property p_wide32;
    @(posedge MCLK) disable iff (RST)
      (state_r == ST_RD && req_r.width == WIDTH_32 && EXT_ACK) |=>
        RDATA_VALID && INT_READ_DATA == $past(EXT_DATA_BUS);
  endproperty
  a_wide32: assert property (p_wide32) else $error("32-bit read not straight");

  property p_beats16;
    @(posedge MCLK) disable iff (RST)
      (state_r == ST_RD && req_r.width == WIDTH_16) |->
        last_r == ((req_r.size == SIZE_WORD) ? 2'h1 : 2'h0);
  endproperty
  a_beats16: assert property (p_beats16) else $error("16-bit transfer count wrong");

  property p_lanes_on;
    @(posedge MCLK) disable iff (RST)
      (state_r == ST_RD && read_lane_select_enable_r) |-> BYTE_LANE_SELECT_N == LANES_OFF;
  endproperty
  a_lanes_on: assert property (p_lanes_on) else $error("wide read lane high");

  property p_wr_lanes;
    @(posedge MCLK) disable iff (RST)
      (state_r == ST_WR) |-> BYTE_LANE_SELECT_N == ~wr_lanes(req_r);
  endproperty
  a_wr_lanes: assert property (p_wr_lanes) else $error("write lane selects wrong");

  property p_addr8w;
    @(posedge MCLK) disable iff (RST)
      (state_r == ST_RD && req_r.width == WIDTH_8 && req_r.size == SIZE_WORD) |->
        EXT_ADDRESS == beat_r;
  endproperty
  a_addr8w: assert property (p_addr8w) else $error("8-bit word address wrong");

  property p_byte8;
    @(posedge MCLK) disable iff (RST)
      (state_r == ST_RD && req_r.width == WIDTH_8 && req_r.size == SIZE_BYTE) |->
        EXT_ADDRESS == req_r.addr;
  endproperty
  a_byte8: assert property (p_byte8) else $error("8-bit byte address wrong");

  property p_addr16;
    @(posedge MCLK) disable iff (RST)
      (state_r == ST_RD && req_r.width == WIDTH_16) |->
        EXT_ADDRESS == ((req_r.size == SIZE_WORD) ? {beat_r[0], 1'b0} : {req_r.addr[1], 1'b0});
  endproperty
  a_addr16: assert property (p_addr16) else $error("16-bit address wrong");

  property p_half16;
    @(posedge MCLK) disable iff (RST)
      (state_r == ST_RD && req_r.width == WIDTH_16 && req_r.size == SIZE_HALF &&
       EXT_ACK) |=> INT_READ_DATA[16*req_r.addr[1] +: 16] == $past(ext_low);
  endproperty
  a_half16: assert property (p_half16) else $error("16-bit halfword lane wrong");

  property p_byte16;
    @(posedge MCLK) disable iff (RST)
      (state_r == ST_RD && req_r.width == WIDTH_16 && req_r.size == SIZE_BYTE &&
       EXT_ACK) |=> INT_READ_DATA[8*req_r.addr +: 8] ==
                    8'($past(ext_low) >> (8 * req_r.addr[0]));
  endproperty
  a_byte16: assert property (p_byte16) else $error("16-bit byte lane wrong");

  property p_pulse;
    @(posedge MCLK) disable iff (RST)
      RDATA_VALID |=> !RDATA_VALID;
  endproperty
  a_pulse: assert property (p_pulse) else $error("read valid longer than one cycle");
endmodule

// file: test/ext_mem_model.sv
// Purpose: external static memory of one bank
// Assumes: each strobed transfer acked after SLOW extra cycles
// Notes:   bus shows inverse of last value while unselected
`timescale 1ns/1ps
module ext_mem_model (
  input  wire logic         MCLK,
  input  wire logic         RST,
  input  wire logic         EXT_STROBE,
  input  wire logic [1:0]   EXT_ADDRESS,
  input  wire logic [127:0] CONTENT,
  input  wire logic [1:0]   SLOW,
  output logic              EXT_ACK,
  output logic [31:0]       EXT_DATA_BUS
);
  logic [1:0]  wait_r;
  logic [31:0] last_r;
  assign EXT_DATA_BUS = EXT_STROBE ? CONTENT[{EXT_ADDRESS, 5'h0} +: 32] : ~last_r;
  always_ff @(posedge MCLK) begin
    if (RST || !EXT_STROBE || EXT_ACK) begin
      EXT_ACK <= 1'b0;
      wait_r  <= 2'h0;
    end else if (wait_r == SLOW) begin
      EXT_ACK <= 1'b1;
    end else begin
      wait_r <= wait_r + 2'h1;
    end
  end
  always_ff @(posedge MCLK) begin
    if (RST) begin
      last_r <= 32'h0;
    end else if (EXT_STROBE) begin
      last_r <= EXT_DATA_BUS;
    end
  end
endmodule

// file: test/tb.sv
// Purpose: self-checking bench for lane_steer
// Assumes: partner memory acks promptly or slowly
// Notes:   only mapped read lanes are compared
`timescale 1ns/1ps
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin mismatches++; \
  $display("Error %s expected %h seen %h", nm, e, g); end end
module tb;
  import lane_steer_pkg::*;
  logic mclk, rst, req_valid, req_write, rle, ext_ack, req_ready, ext_strobe, rdata_valid;
  req_s req;
  logic [1:0]   ext_address, slow;
  logic [3:0]   sel_n, drv_n;
  logic [31:0]  int_write_data, ext_data_bus, ext_write_data, int_read_data;
  logic [127:0] c;
  int mismatches, samples_checked, acks, cycles;
  logic rd_on;
  logic [63:0] wx;
  logic [1:0]  xa;
  lane_steer i_dut (.MCLK(mclk), .RST(rst), .REQ_VALID(req_valid), .REQ_WRITE(req_write),
    .REQ(req), .READ_LANE_SELECT_ENABLE(rle), .INT_WRITE_DATA(int_write_data),
    .EXT_DATA_BUS(ext_data_bus), .EXT_ACK(ext_ack), .REQ_READY(req_ready),
    .EXT_STROBE(ext_strobe), .EXT_ADDRESS(ext_address), .BYTE_LANE_SELECT_N(sel_n),
    .WRITE_LANE_DRIVE_EN_N(drv_n), .EXT_WRITE_DATA(ext_write_data),
    .INT_READ_DATA(int_read_data), .RDATA_VALID(rdata_valid));
  ext_mem_model i_mem (.MCLK(mclk), .RST(rst), .EXT_STROBE(ext_strobe),
    .EXT_ADDRESS(ext_address), .CONTENT(c), .SLOW(slow), .EXT_ACK(ext_ack),
    .EXT_DATA_BUS(ext_data_bus));
  // returns {lane mask, masked expected data}
  function automatic logic [63:0] expect_rd(logic [1:0] w, s, a, logic [127:0] d);
    logic [31:0] m, v;
    int idx, b;
    m = (s == SIZE_WORD) ? 32'hFFFFFFFF : (s == SIZE_HALF) ?
        (a[1] ? 32'hFFFF0000 : 32'h0000FFFF) : (32'hFF << (8 * a));
    for (int k = 0; k < 4; k++) begin
      idx = (w == WIDTH_8) ? k : (w == WIDTH_16) ? (k & 2) : 0;
      b = (w == WIDTH_8) ? 0 : (w == WIDTH_16) ? (k & 1) : k;
      v[8*k +: 8] = d[idx*32 + b*8 +: 8];
    end
    return {m, v & m};
  endfunction
  function automatic int n_xfer(logic [1:0] w, s);
    if (w == WIDTH_8) return (s == SIZE_WORD) ? 4 : (s == SIZE_HALF) ? 2 : 1;
    if (w == WIDTH_16) return (s == SIZE_WORD) ? 2 : 1;
    return 1;
  endfunction
  // external address of transfer k, ascending from the access base
  function automatic logic [1:0] xaddr(logic [1:0] w, s, a, int k);
    if (w == WIDTH_8) return (s == SIZE_WORD) ? 2'(k) : (s == SIZE_HALF) ? {a[1], 1'(k)} : a;
    if (w == WIDTH_16) return (s == SIZE_WORD) ? {1'(k), 1'b0} : {a[1], 1'b0};
    return 2'h0;
  endfunction
  // returns {lane mask, masked expected write data} for external address x
  function automatic logic [63:0] expect_wr(logic [1:0] w, s, a, x, logic [31:0] d);
    logic [3:0]  l;
    logic [31:0] m, v;
    if (w == WIDTH_8) l = 4'h1;
    else if (w == WIDTH_16) l = (s == SIZE_BYTE) ? 4'(1 << a[0]) : 4'h3;
    else if (s == SIZE_WORD) l = 4'hF;
    else if (s == SIZE_HALF) l = a[1] ? 4'hC : 4'h3;
    else l = 4'(1 << a);
    m = {{8{l[3]}}, {8{l[2]}}, {8{l[1]}}, {8{l[0]}}};
    v = (w == WIDTH_8) ? {24'h0, d[8*x +: 8]} : (w == WIDTH_16) ? {16'h0, d[16*x[1] +: 16]} : d;
    return {m, v & m};
  endfunction
  task automatic tally_and_finish();
    $display("Checked %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic issue(logic wr, logic [1:0] w, s, a, logic en);
    acks = 0;
    do @(posedge mclk); while (req_ready !== 1'b1);
    req <= '{size: s, addr: a, width: w};
    req_write <= wr;
    rle <= en;
    int_write_data <= $urandom;
    req_valid <= 1'b1;
    @(posedge mclk);
    req_valid <= 1'b0;
  endtask
  task automatic rd(logic [1:0] w, s, a);
    logic [63:0] ex;
    int n;
    c = {$urandom, $urandom, $urandom, $urandom};
    if (w == WIDTH_16) c = {c[95:64], c[95:64], c[31:0], c[31:0]};
    if (w == WIDTH_32) c = {4{c[31:0]}};
    slow = 2'($urandom % 4);
    ex = expect_rd(w, s, a, c);
    rd_on = 1'b1;
    issue(1'b0, w, s, a, w != WIDTH_8);
    n = 0;
    do begin @(posedge mclk); n++; end while (rdata_valid !== 1'b1 && n < 60);
    `CHK("rdata_valid", 1'b1, rdata_valid)
    `CHK("read_data", ex[31:0], int_read_data & ex[63:32])
    `CHK("transfers", n_xfer(w, s), acks)
    @(posedge mclk);
    `CHK("valid_pulse", 1'b0, rdata_valid)
    `CHK("rdata_hold", ex[31:0], int_read_data & ex[63:32])
    rd_on = 1'b0;
  endtask
  task automatic wr(logic [1:0] w, s, a);
    slow = 2'($urandom % 4);
    issue(1'b1, w, s, a, 1'b0);
    do @(posedge mclk); while (req_ready !== 1'b1);
    `CHK("wr_transfers", n_xfer(w, s), acks)
  endtask
  always @(posedge mclk) begin
    cycles++;
    if (ext_ack === 1'b1) begin
      xa = xaddr(req.width, req.size, req.addr, acks);
      wx = expect_wr(req.width, req.size, req.addr, xa, int_write_data);
      `CHK("ext_addr", xa, ext_address)
      if (req_write) `CHK("wr_sel", ~{wx[56], wx[48], wx[40], wx[32]}, sel_n)
      if (req_write) `CHK("wr_data", wx[31:0], ext_write_data & wx[63:32])
      acks++;
    end
    if (rd_on && ext_strobe === 1'b1) `CHK("lane_sel", (rle ? 4'h0 : 4'hF), sel_n)
    if (!rst) `CHK("drive_en", 4'h0, drv_n)
    if (cycles == 20000) begin
      mismatches++;
      tally_and_finish();
    end
  end
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  initial begin
    rst = 1'b1; req_valid = 1'b0; req_write = 1'b0; req = '0; rle = 1'b0; rd_on = 1'b0;
    int_write_data = 32'h0; c = '0; slow = 2'h0;
    void'($urandom(12756));
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    for (int w = 0; w < 3; w++)
      for (int s = 0; s < 3; s++)
        for (int a = 0; a < 4; a++) rd(2'(w), 2'(s), 2'(a));
    repeat (30) rd(2'($urandom % 3), 2'($urandom % 3), 2'($urandom % 4));
    for (int w = 0; w < 3; w++)
      for (int s = 0; s < 3; s++)
        for (int a = 0; a < 4; a++) wr(2'(w), 2'(s), 2'(a));
    repeat (30) begin
      if ($urandom % 2) wr(2'($urandom % 3), 2'($urandom % 3), 2'($urandom % 4));
      else rd(2'($urandom % 3), 2'($urandom % 3), 2'($urandom % 4));
    end
    tally_and_finish();
  end
endmodule
